//--- rtl/sfcu_pkg.sv
package sfcu_pkg;

  localparam int unsigned    SFCU_XLEN        = 32;
  localparam logic [31:0]    SFCU_PC_STEP     = 32'h0000_0004;
  localparam logic [31:0]    SFCU_WORD_MASK   = 32'hFFFF_FFFC;
  localparam int unsigned    SFCU_ADR_SHIFT   = 2;
  localparam logic [7:0]     SFCU_ROT_FULL    = 8'h20;
  localparam logic [3:0]     SFCU_FLAGS_RST   = 4'h0;
  localparam logic [31:0]    SFCU_RESULT_RST  = 32'h0000_0000;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } sfcu_flags_t;

  typedef enum logic [3:0] {
    SFCU_OP_NOP   = 4'h0,
    SFCU_OP_ADD   = 4'h1,
    SFCU_OP_ADDS  = 4'h2,
    SFCU_OP_SUBS  = 4'h3,
    SFCU_OP_CSUB  = 4'h4,
    SFCU_OP_CADD  = 4'h5,
    SFCU_OP_ROTR  = 4'h6,
    SFCU_OP_ROTRS = 4'h7,
    SFCU_OP_ADR   = 4'h8,
    SFCU_OP_MOVS  = 4'h9
  } sfcu_op_t;

  typedef enum logic [1:0] {
    SFCU_SZ_BYTE  = 2'h0,
    SFCU_SZ_HALF  = 2'h1,
    SFCU_SZ_WORD  = 2'h2,
    SFCU_SZ_MULTI = 2'h3
  } sfcu_size_t;

  typedef enum logic [3:0] {
    SFCU_CC_EQ = 4'h0, SFCU_CC_NE = 4'h1, SFCU_CC_HS = 4'h2, SFCU_CC_LO = 4'h3,
    SFCU_CC_MI = 4'h4, SFCU_CC_PL = 4'h5, SFCU_CC_VS = 4'h6, SFCU_CC_VC = 4'h7,
    SFCU_CC_HI = 4'h8, SFCU_CC_LS = 4'h9, SFCU_CC_GE = 4'hA, SFCU_CC_LT = 4'hB,
    SFCU_CC_GT = 4'hC, SFCU_CC_LE = 4'hD, SFCU_CC_AL = 4'hE, SFCU_CC_NV = 4'hF
  } sfcu_cond_t;

  typedef struct packed {
    sfcu_flags_t flags;
    logic [31:0] result;
    logic        result_we;
    logic        fault;
    logic [31:0] fault_addr;
  } sfcu_state_t;

endpackage : sfcu_pkg

//--- rtl/sfcu_dp_if.sv
`timescale 1ns/1ps
interface sfcu_dp_if;
  import sfcu_pkg::*;
  logic [31:0] rot_src;
  logic [7:0]  rot_amt;
  logic [31:0] rot_res;
  logic        rot_carry;
  logic        rot_keep;
  sfcu_flags_t flags;
  logic [3:0]  cond;
  logic        taken;
  modport rot (input rot_src, rot_amt, output rot_res, rot_carry, rot_keep);
  modport cnd (input flags, cond, output taken);
  modport top (output rot_src, rot_amt, flags, cond, input rot_res, rot_carry, rot_keep, taken);
endinterface : sfcu_dp_if

//--- rtl/sfcu_rotator.sv
`timescale 1ns/1ps
module sfcu_rotator
  import sfcu_pkg::*;
(
  sfcu_dp_if.rot dp
);
  logic [4:0]  k;
  logic [63:0] dbl;

  // lengths above 32 fold down by 32 until 1..32 remain
  assign k   = dp.rot_amt[4:0];
  assign dbl = {dp.rot_src, dp.rot_src} >> k;
  assign dp.rot_res = dbl[31:0];
  // last bit out is always the new top bit, covers n==32 too
  assign dp.rot_carry = dbl[31];
  assign dp.rot_keep  = (dp.rot_amt == 8'h00);
endmodule : sfcu_rotator

//--- rtl/sfcu_cond_eval.sv
`timescale 1ns/1ps
module sfcu_cond_eval
  import sfcu_pkg::*;
(
  sfcu_dp_if.cnd dp
);
  function automatic logic cond_ok(input logic [3:0] cc, input sfcu_flags_t f);
    logic r;
    r = 1'b0;
    unique case (cc)
      SFCU_CC_EQ: r = f.z;
      SFCU_CC_NE: r = ~f.z;
      SFCU_CC_HS: r = f.c;
      SFCU_CC_LO: r = ~f.c;
      SFCU_CC_MI: r = f.n;
      SFCU_CC_PL: r = ~f.n;
      SFCU_CC_VS: r = f.v;
      SFCU_CC_VC: r = ~f.v;
      SFCU_CC_HI: r = f.c & ~f.z;
      SFCU_CC_LS: r = ~f.c | f.z;
      SFCU_CC_GE: r = (f.n == f.v);
      SFCU_CC_LT: r = (f.n != f.v);
      SFCU_CC_GT: r = ~f.z & (f.n == f.v);
      SFCU_CC_LE: r = f.z | (f.n != f.v);
      SFCU_CC_AL: r = 1'b1;
      default:    r = 1'b0;
    endcase
    return r;
  endfunction : cond_ok

  // purely combinational so the sequencer sees it in the decode cycle
  assign dp.taken = cond_ok(dp.cond, dp.flags);
endmodule : sfcu_cond_eval

//--- rtl/sfcu_top.sv
`timescale 1ns/1ps
module sfcu_top
  import sfcu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        op_valid,
  input  wire sfcu_op_t    op_code,
  input  wire logic [31:0] operand_a,
  input  wire logic [31:0] source_operand,
  input  wire logic [7:0]  rot_amount,
  input  wire logic [7:0]  adr_imm,
  input  wire logic [31:0] instr_addr,
  output logic [31:0]      program_counter,
  output logic [31:0]      result_q,
  output logic             result_we_q,
  output logic [3:0]       program_status_flags,
  input  wire logic        branch_valid,
  input  wire logic [3:0]  branch_cond,
  output logic             branch_taken,
  input  wire logic        mem_req,
  input  wire sfcu_size_t  mem_size,
  input  wire logic [31:0] mem_addr,
  output logic             mem_go,
  output logic             fatal_fault_exception,
  output logic [31:0]      fault_addr_q
);

  sfcu_state_t s_q;
  sfcu_state_t s_d;
  logic [32:0] sum_add;
  logic [32:0] sum_sub;
  logic        v_add;
  logic        v_sub;
  logic [31:0] adr_base;
  logic [31:0] adr_sum;
  logic        misaligned;

  sfcu_dp_if dp ();

  sfcu_rotator u_rot (
    .dp (dp)
  );

  sfcu_cond_eval u_cond (
    .dp (dp)
  );

  assign dp.rot_src = source_operand;
  assign dp.rot_amt = rot_amount;
  assign dp.flags   = s_q.flags;
  assign dp.cond    = branch_cond;

  function automatic logic is_misaligned(input sfcu_size_t sz, input logic [1:0] lo);
    logic r;
    r = 1'b0;
    unique case (sz)
      SFCU_SZ_BYTE:  r = 1'b0;
      SFCU_SZ_HALF:  r = lo[0];
      SFCU_SZ_WORD:  r = (lo != 2'b00);
      SFCU_SZ_MULTI: r = (lo != 2'b00);
    endcase
    return r;
  endfunction : is_misaligned

  assign program_counter = instr_addr + SFCU_PC_STEP;

  // subtract is a + ~b + 1, so bit 32 is the no-borrow carry
  assign sum_add = {1'b0, operand_a} + {1'b0, source_operand};
  assign sum_sub = {1'b0, operand_a} + {1'b0, ~source_operand} + 33'h0_0000_0001;
  assign v_add = (operand_a[31] == source_operand[31]) & (sum_add[31] != operand_a[31]);
  assign v_sub = (operand_a[31] != source_operand[31]) & (sum_sub[31] != operand_a[31]);

  // base is word aligned so every generated target is word aligned
  assign adr_base = program_counter & SFCU_WORD_MASK;
  assign adr_sum  = adr_base + {22'h00_0000, adr_imm, 2'b00};

  assign misaligned = is_misaligned(mem_size, mem_addr[1:0]);
  // blocked in the same cycle so the access never completes
  assign mem_go = mem_req & ~misaligned;

  // only taken while a branch is being decoded
  assign branch_taken = branch_valid & dp.taken;

  always_comb
  begin
    s_d           = s_q;
    s_d.result_we = 1'b0;
    s_d.fault     = 1'b0;
    if (op_valid)
    begin
      unique case (op_code)
        SFCU_OP_NOP:
        begin
          s_d.result_we = 1'b0;
        end
        SFCU_OP_ADD:
        begin
          s_d.result    = sum_add[31:0];
          s_d.result_we = 1'b1;
        end
        SFCU_OP_ADDS, SFCU_OP_CADD:
        begin
          s_d.flags.n = sum_add[31];
          s_d.flags.z = (sum_add[31:0] == 32'h0000_0000);
          s_d.flags.c = sum_add[32];
          s_d.flags.v = v_add;
          if (op_code == SFCU_OP_ADDS)
          begin
            s_d.result    = sum_add[31:0];
            s_d.result_we = 1'b1;
          end
        end
        SFCU_OP_SUBS, SFCU_OP_CSUB:
        begin
          s_d.flags.n = sum_sub[31];
          s_d.flags.z = (sum_sub[31:0] == 32'h0000_0000);
          s_d.flags.c = sum_sub[32];
          s_d.flags.v = v_sub;
          // compares keep result and leave the write strobe low
          if (op_code == SFCU_OP_SUBS)
          begin
            s_d.result    = sum_sub[31:0];
            s_d.result_we = 1'b1;
          end
        end
        SFCU_OP_ROTR:
        begin
          s_d.result    = dp.rot_res;
          s_d.result_we = 1'b1;
        end
        SFCU_OP_ROTRS:
        begin
          // ROTRS sets N and Z, and C unless the length is zero; V keeps its value
          s_d.result    = dp.rot_res;
          s_d.result_we = 1'b1;
          s_d.flags.n   = dp.rot_res[31];
          s_d.flags.z   = (dp.rot_res == 32'h0000_0000);
          if (!dp.rot_keep)
          begin
            s_d.flags.c = dp.rot_carry;
          end
        end
        SFCU_OP_ADR:
        begin
          s_d.result    = adr_sum;
          s_d.result_we = 1'b1;
        end
        SFCU_OP_MOVS:
        begin
          s_d.result    = source_operand;
          s_d.result_we = 1'b1;
          s_d.flags.n   = source_operand[31];
          s_d.flags.z   = (source_operand == 32'h0000_0000);
        end
        default:
        begin
          s_d.result_we = 1'b0;
        end
      endcase
    end
    if (mem_req && misaligned)
    begin
      s_d.fault      = 1'b1;
      s_d.fault_addr = mem_addr;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q.flags      <= SFCU_FLAGS_RST;
      s_q.result     <= SFCU_RESULT_RST;
      s_q.result_we  <= 1'b0;
      s_q.fault      <= 1'b0;
      s_q.fault_addr <= SFCU_RESULT_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign result_q              = s_q.result;
  assign result_we_q           = s_q.result_we;
  assign program_status_flags  = s_q.flags;
  assign fatal_fault_exception = s_q.fault;
  assign fault_addr_q          = s_q.fault_addr;

  // one fold checked here, lengths past 64 only by the bench
  property p_rot_wrap;
    @(posedge clk) disable iff (rst)
    op_valid && (op_code inside {SFCU_OP_ROTR, SFCU_OP_ROTRS})
      && (rot_amount > SFCU_ROT_FULL) && (rot_amount <= 8'h40)
    |=> result_q
        == 32'($past({source_operand, source_operand} >> (rot_amount - SFCU_ROT_FULL)));
  endproperty
  a_rot_wrap: assert property (p_rot_wrap) else $error("long rotate not folded");

  property p_rot_full;
    @(posedge clk) disable iff (rst)
    op_valid && (op_code == SFCU_OP_ROTRS) && (rot_amount == SFCU_ROT_FULL)
    |=> (result_q == $past(source_operand))
        && (program_status_flags[1] == $past(source_operand[31]));
  endproperty
  a_rot_full: assert property (p_rot_full) else $error("rotate by 32 wrong");

  property p_rot_carry;
    @(posedge clk) disable iff (rst)
    op_valid && (op_code == SFCU_OP_ROTRS) && (rot_amount > 8'h00)
      && (rot_amount < SFCU_ROT_FULL)
    |=> program_status_flags[1] == $past(source_operand[rot_amount[4:0] - 5'h01]);
  endproperty
  a_rot_carry: assert property (p_rot_carry) else $error("rotate carry wrong");

  property p_rot_zero;
    @(posedge clk) disable iff (rst)
    op_valid && (op_code == SFCU_OP_ROTRS) && (rot_amount == 8'h00)
    |=> (result_q == $past(source_operand)) && $stable(program_status_flags[1]);
  endproperty
  a_rot_zero: assert property (p_rot_zero) else $error("zero rotate changed carry");

  property p_fault;
    @(posedge clk) disable iff (rst)
    mem_req && (mem_size != SFCU_SZ_BYTE) && (mem_addr[0] == 1'b1)
    |-> !mem_go ##1 fatal_fault_exception && (fault_addr_q == $past(mem_addr));
  endproperty
  a_fault: assert property (p_fault) else $error("odd address not faulted");

  property p_byte_ok;
    @(posedge clk) disable iff (rst)
    mem_req && (mem_size == SFCU_SZ_BYTE) |-> mem_go;
  endproperty
  a_byte_ok: assert property (p_byte_ok) else $error("byte access blocked");

  property p_compare_nowrite;
    @(posedge clk) disable iff (rst)
    op_valid && ((op_code == SFCU_OP_CSUB) || (op_code == SFCU_OP_CADD))
    |=> !result_we_q && $stable(result_q);
  endproperty
  a_compare_nowrite: assert property (p_compare_nowrite) else $error("compare wrote result");

  property p_adr;
    @(posedge clk) disable iff (rst)
    op_valid && (op_code == SFCU_OP_ADR)
    |=> $stable(program_status_flags)
        && (result_q == ((($past(instr_addr) + 32'h0000_0004) & 32'hFFFF_FFFC)
                         + {22'h00_0000, $past(adr_imm), 2'b00}));
  endproperty
  a_adr: assert property (p_adr) else $error("pc-relative address wrong");

  property p_add_flags;
    @(posedge clk) disable iff (rst)
    op_valid && (op_code == SFCU_OP_ADDS)
    |=> (program_status_flags[1] == ($past({1'b0, operand_a} + {1'b0, source_operand}) > 33'h0_FFFF_FFFF))
        && (program_status_flags[2] == (result_q == 32'h0000_0000))
        && (program_status_flags[3] == result_q[31]);
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

  property p_movs_keep;
    @(posedge clk) disable iff (rst)
    op_valid && (op_code == SFCU_OP_MOVS)
    |=> $stable(program_status_flags[1:0]);
  endproperty
  a_movs_keep: assert property (p_movs_keep) else $error("partial update lost flags");

  property p_branch;
    @(posedge clk) disable iff (rst)
    branch_valid && (branch_cond == SFCU_CC_GT)
    |-> branch_taken == (!program_status_flags[2]
                         && (program_status_flags[3] == program_status_flags[0]));
  endproperty
  a_branch: assert property (p_branch) else $error("signed greater wrong");

  property p_always;
    @(posedge clk) disable iff (rst)
    branch_valid && (branch_cond == SFCU_CC_AL) |-> branch_taken;
  endproperty
  a_always: assert property (p_always) else $error("always branch not taken");

endmodule : sfcu_top

//--- verif/sfcu_seq_model.sv
`timescale 1ns/1ps
module sfcu_seq_model
  import sfcu_pkg::*;
(
  input  wire logic   clk,
  output logic        op_valid,
  output sfcu_op_t    op_code,
  output logic [31:0] operand_a,
  output logic [31:0] source_operand,
  output logic [7:0]  rot_amount,
  output logic [7:0]  adr_imm,
  output logic [31:0] instr_addr,
  output logic        branch_valid,
  output logic [3:0]  branch_cond,
  output logic        mem_req,
  output sfcu_size_t  mem_size,
  output logic [31:0] mem_addr
);
  initial
  begin
    {op_valid, branch_valid, mem_req} = 3'h0;
    op_code = SFCU_OP_NOP;
    {operand_a, source_operand, instr_addr, mem_addr} = '0;
    {rot_amount, adr_imm, branch_cond} = '0;
    mem_size = SFCU_SZ_BYTE;
  end

  // operands inverted once taken, so stale values never pass for fresh ones
  task automatic op(input sfcu_op_t c, input logic [31:0] a, input logic [31:0] b,
                    input logic [7:0] n);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    {operand_a, instr_addr, source_operand} <= {a, a, b};
    {rot_amount, adr_imm} <= {n, n};
    @(posedge clk);
    op_valid <= 1'b0;
    {operand_a, source_operand} <= {~a, ~b};
  endtask : op

  task automatic br_on(input logic [3:0] c);
    @(posedge clk);
    branch_valid <= 1'b1;
    branch_cond <= c;
  endtask : br_on

  task automatic br_off();
    @(posedge clk);
    branch_valid <= 1'b0;
  endtask : br_off

  task automatic mem_on(input sfcu_size_t s, input logic [31:0] a);
    @(posedge clk);
    mem_req <= 1'b1;
    mem_size <= s;
    mem_addr <= a;
  endtask : mem_on

  task automatic mem_off();
    @(posedge clk);
    mem_req <= 1'b0;
    mem_addr <= ~mem_addr;
  endtask : mem_off
endmodule : sfcu_seq_model

//--- verif/shift_flag_condition_unit_tb.sv
`timescale 1ns/1ps
module shift_flag_condition_unit_tb
  import sfcu_pkg::*;
;
  logic        clk, rst, op_valid, result_we_q, branch_valid, branch_taken;
  logic        mem_req, mem_go, fatal_fault_exception;
  sfcu_op_t    op_code;
  sfcu_size_t  mem_size;
  logic [31:0] operand_a, source_operand, instr_addr, program_counter, result_q;
  logic [31:0] mem_addr, fault_addr_q, exp_res;
  logic [7:0]  rot_amount, adr_imm;
  logic [3:0]  program_status_flags, branch_cond, exp_flags;
  int          err_total, checks_done;

  sfcu_top sfcu_top_inst (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .operand_a(operand_a), .source_operand(source_operand), .rot_amount(rot_amount),
    .adr_imm(adr_imm), .instr_addr(instr_addr), .program_counter(program_counter),
    .result_q(result_q), .result_we_q(result_we_q),
    .program_status_flags(program_status_flags), .branch_valid(branch_valid),
    .branch_cond(branch_cond), .branch_taken(branch_taken), .mem_req(mem_req),
    .mem_size(mem_size), .mem_addr(mem_addr), .mem_go(mem_go),
    .fatal_fault_exception(fatal_fault_exception), .fault_addr_q(fault_addr_q));

  sfcu_seq_model sfcu_seq_model_inst (.clk(clk), .op_valid(op_valid), .op_code(op_code),
    .operand_a(operand_a), .source_operand(source_operand), .rot_amount(rot_amount),
    .adr_imm(adr_imm), .instr_addr(instr_addr), .branch_valid(branch_valid),
    .branch_cond(branch_cond), .mem_req(mem_req), .mem_size(mem_size),
    .mem_addr(mem_addr));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic n, z, k, v;
    logic [15:0] t;
    {n, z, k, v} = f;
    t = {1'b0, 1'b1, z | (n ^ v), !z & !(n ^ v), n ^ v, !(n ^ v), !k | z, k & !z,
         !v, v, !n, n, !k, k, !z, z};
    return t[c];
  endfunction : cond_ok

  // expectation worked out here, then one op through the model and result, write strobe, flags and program_counter compared
  task automatic run_op(input sfcu_op_t c, input logic [31:0] a, input logic [31:0] b,
                        input logic [7:0] n);
    logic [32:0] s;
    logic [31:0] r;
    logic [3:0]  f;
    logic        wr, setnz;
    int          m;
    f = exp_flags;
    r = b;
    m = n % 32;
    setnz = 1'b1;
    wr = c inside {SFCU_OP_ADD, SFCU_OP_ADDS, SFCU_OP_SUBS, SFCU_OP_ROTR, SFCU_OP_ROTRS,
                   SFCU_OP_ADR, SFCU_OP_MOVS};
    case (c)
      SFCU_OP_ADD: r = a + b;
      SFCU_OP_ADDS, SFCU_OP_CADD:
      begin
        s = {1'b0, a} + {1'b0, b};
        r = s[31:0];
        f[1:0] = {s[32], (a[31] == b[31]) && (r[31] != a[31])};
      end
      SFCU_OP_SUBS, SFCU_OP_CSUB:
      begin
        r = a - b;
        f[1:0] = {a >= b, (a[31] != b[31]) && (r[31] != a[31])};
      end
      SFCU_OP_ROTR, SFCU_OP_ROTRS:
      begin
        if (m != 0)
          r = (b >> m) | (b << (32 - m));
        if (n != 0)
          f[1] = (m == 0) ? b[31] : b[m-1];
      end
      SFCU_OP_ADR: r = ((a + SFCU_PC_STEP) & SFCU_WORD_MASK) + 32'({n, 2'h0});
      SFCU_OP_MOVS: ;
      default: wr = 1'b0;
    endcase
    if (c inside {SFCU_OP_ADD, SFCU_OP_ROTR, SFCU_OP_ADR, SFCU_OP_NOP})
      setnz = 1'b0;
    if (setnz)
      f[3:2] = {r[31], r == 32'h0000_0000};
    else
      f = exp_flags;
    exp_flags = f;
    if (wr)
      exp_res = r;
    sfcu_seq_model_inst.op(c, a, b, n);
    #1;
    chk("result_we_q", result_we_q, wr);
    chk("result_q", result_q, exp_res);
    chk("flags", program_status_flags, exp_flags);
    chk("program_counter", program_counter, a + SFCU_PC_STEP);
    @(posedge clk);
    #1;
    chk("result_we_q idle", result_we_q, 1'b0);
  endtask : run_op

  task automatic t_reset();
    #1;
    chk("flags reset", program_status_flags, SFCU_FLAGS_RST);
    chk("result reset", result_q, SFCU_RESULT_RST);
    chk("fault reset", fatal_fault_exception, 1'b0);
    $display("test reset finished");
  endtask : t_reset

  task automatic t_rotate();
    logic [7:0] amt [8] = '{8'h03, 8'h20, 8'h00, 8'h23, 8'h40, 8'h01, 8'hFF, 8'h1F};
    foreach (amt[i])
      run_op(SFCU_OP_ROTRS, 32'h0000_0000, 32'h8765_4321, amt[i]);
    run_op(SFCU_OP_ROTR, 32'h0000_0000, 32'h0000_00F0, 8'h24);
    $display("test rotate finished");
  endtask : t_rotate

  // each flag state is followed by every condition code
  task automatic t_cond();
    sfcu_op_t    o [8] = '{SFCU_OP_ADDS, SFCU_OP_ADDS, SFCU_OP_ADDS, SFCU_OP_SUBS,
                           SFCU_OP_SUBS, SFCU_OP_SUBS, SFCU_OP_CSUB, SFCU_OP_CADD};
    logic [31:0] a [8] = '{32'h0000_0001, 32'h7FFF_FFFF, 32'h8000_0000, 32'h0000_0005,
                           32'h0000_0003, 32'h8000_0000, 32'h7FFF_FFFF, 32'h0000_0001};
    logic [31:0] b [8] = '{32'hFFFF_FFFF, 32'h0000_0001, 32'h8000_0000, 32'h0000_0005,
                           32'h0000_0005, 32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_0001};
    foreach (o[k])
    begin
      run_op(o[k], a[k], b[k], 8'h00);
      for (int c = 0; c < 16; c++)
      begin
        sfcu_seq_model_inst.br_on(c[3:0]);
        #1;
        chk("branch_taken", branch_taken, cond_ok(c[3:0], exp_flags));
      end
      sfcu_seq_model_inst.br_off();
      #1;
      chk("branch idle", branch_taken, 1'b0);
    end
    $display("test conditions finished");
  endtask : t_cond

  task automatic t_partial();
    run_op(SFCU_OP_ADDS, 32'h7FFF_FFFF, 32'h0000_0001, 8'h00);
    run_op(SFCU_OP_MOVS, 32'h0000_0000, 32'h0000_0000, 8'h00);
    run_op(SFCU_OP_ADD, 32'h0000_0003, 32'h0000_0004, 8'h00);
    run_op(SFCU_OP_ADR, 32'h0000_1002, 32'h0000_0000, 8'hFF);
    run_op(SFCU_OP_ADR, 32'h0000_2000, 32'h0000_0000, 8'h00);
    run_op(SFCU_OP_NOP, 32'h0000_0005, 32'h0000_0006, 8'h01);
    $display("test partial flags finished");
  endtask : t_partial

  task automatic t_mem();
    sfcu_size_t  s [8] = '{SFCU_SZ_BYTE, SFCU_SZ_HALF, SFCU_SZ_HALF, SFCU_SZ_WORD,
                           SFCU_SZ_WORD, SFCU_SZ_MULTI, SFCU_SZ_MULTI, SFCU_SZ_WORD};
    logic [31:0] ad [8] = '{32'h0000_1003, 32'h0000_1002, 32'h0000_1001, 32'h0000_1004,
                            32'h0000_1002, 32'h0000_1001, 32'h0000_1008, 32'h0000_1003};
    logic        ok;
    logic [31:0] fa;
    fa = fault_addr_q;
    foreach (s[k])
    begin
      ok = (s[k] == SFCU_SZ_BYTE) || (s[k] == SFCU_SZ_HALF ? !ad[k][0] : ad[k][1:0] == 2'h0);
      sfcu_seq_model_inst.mem_on(s[k], ad[k]);
      #1;
      chk("mem_go", mem_go, ok);
      sfcu_seq_model_inst.mem_off();
      #1;
      if (!ok)
        fa = ad[k];
      chk("fault pulse", fatal_fault_exception, !ok);
      chk("fault_addr_q", fault_addr_q, fa);
      @(posedge clk);
      #1;
      chk("fault end", fatal_fault_exception, 1'b0);
    end
    $display("test alignment finished");
  endtask : t_mem

  initial
  begin
    rst = 1'b1;
    err_total = 0;
    checks_done = 0;
    exp_flags = SFCU_FLAGS_RST;
    exp_res = SFCU_RESULT_RST;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rotate();
    t_cond();
    t_partial();
    t_mem();
    conclude();
  end

  // whole run needs well under 1000 cycles
  initial
  begin
    #20_000;
    err_total++;
    conclude();
  end
endmodule : shift_flag_condition_unit_tb
